/* File: sfrep_pkg.sv */
// Shared constants and types for the serial flash command sequencer
package sfrep_pkg;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] CMD_LOW_POWER_READ = 8'h03;
  localparam logic [7:0] CMD_FAST_READ = 8'h0b;
  localparam logic [7:0] CMD_DUAL_OUTPUT_READ = 8'h3b;
  localparam logic [7:0] CMD_DUAL_IO_READ = 8'hbb;
  localparam logic [7:0] CMD_SMALL_BLOCK_ERASE_A = 8'h20;
  localparam logic [7:0] CMD_SMALL_BLOCK_ERASE_B = 8'hd7;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] CMD_FULL_ARRAY_ERASE_A = 8'h60;
  localparam logic [7:0] CMD_FULL_ARRAY_ERASE_B = 8'hc7;
  localparam logic [7:0] CMD_PAGE_WRITE = 8'h02;
  localparam logic [7:0] CMD_PAGE_WRITE_LOW_CURRENT = 8'h0a;
  localparam logic [7:0] CMD_WRITE_PAUSE = 8'hb0;
  localparam logic [7:0] CMD_WRITE_CONTINUE = 8'h30;
  localparam logic [7:0] CMD_STATUS_READ = 8'h05;
  localparam logic [7:0] CMD_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] CMD_WRITE_LOCK = 8'h04;

  // ==========================================================================
  // Address layout and status bit positions
  localparam int ADDR_W = 20;
  localparam logic [19:0] ADDR_TOP = 20'hfffff;
  localparam logic [19:0] SMALL_ERASE_MASK = 20'hff000;
  localparam logic [19:0] BLOCK_ERASE_MASK = 20'hf0000;
  localparam logic [19:0] PAGE_MASK = 20'hfff00;
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_PAUSED = 6;

  // ==========================================================================
  // Serial clock counts, each the last index of its phase
  localparam logic [4:0] CMD_LAST = 5'h07;
  localparam logic [4:0] ADDR_LAST_SINGLE = 5'h17;
  localparam logic [4:0] ADDR_LAST_DUAL = 5'h0b;
  localparam logic [4:0] DUMMY_LAST = 5'h07;
  localparam logic [4:0] DUMMY_LAST_DUAL_IO = 5'h03;
  localparam logic [4:0] BYTE_LAST = 5'h07;
  localparam logic [2:0] OUT_STEPS_SINGLE = 3'h7;
  localparam logic [2:0] OUT_STEPS_DUAL = 3'h3;

  // ==========================================================================
  // Timing
  localparam int CLOCK_HZ = 20_000_000;
  localparam int SMALL_ERASE_TIME_MS = 10;
  localparam int BLOCK_ERASE_TIME_MS = 15;
  localparam int FULL_ERASE_TIME_MS = 120;
  localparam int PAGE_WRITE_TIME_US = 500;
  localparam int PAGE_WRITE_LOW_CURRENT_TIME_US = 1000;
  localparam int PAUSE_RECOVERY_TIME_US = 20;
  localparam int SMALL_ERASE_CYC = SMALL_ERASE_TIME_MS * (CLOCK_HZ / 1000);
  localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_MS * (CLOCK_HZ / 1000);
  localparam int FULL_ERASE_CYC = FULL_ERASE_TIME_MS * (CLOCK_HZ / 1000);
  localparam int PAGE_WRITE_CYC = PAGE_WRITE_TIME_US * (CLOCK_HZ / 1_000_000);
  localparam int PAGE_WRITE_LC_CYC =
    PAGE_WRITE_LOW_CURRENT_TIME_US * (CLOCK_HZ / 1_000_000);
  localparam logic [8:0] PAUSE_RECOVERY_CYC =
    9'(PAUSE_RECOVERY_TIME_US * (CLOCK_HZ / 1_000_000));
  localparam int TIMER_W = 22;

  // ==========================================================================
  // Buffer shape
  localparam int BUF_W = 28;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [1:0] {
    OP_SMALL = 2'h0,
    OP_BLOCK = 2'h1,
    OP_FULL = 2'h2,
    OP_PAGE = 2'h3
  } sfrep_op_type;

  typedef enum logic [2:0] {
    PH_CMD = 3'h0,
    PH_ADDR = 3'h1,
    PH_DUMMY = 3'h3,
    PH_DOUT = 3'h2,
    PH_DIN = 3'h6,
    PH_HOLD = 3'h7,
    PH_SKIP = 3'h5
  } sfrep_phase_type;

endpackage

/* File: sfrep_sync.sv */
// Two-stage synchroniser for the serial pins
`timescale 1ns/1ps
module sfrep_sync
  import sfrep_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Pins
  input wire logic [3:0] pinsIn,
  output logic [3:0] pinsOut
);

  typedef struct packed {
    logic [3:0] first;
    logic [3:0] second;
  } sfrep_sync_type;

  sfrep_sync_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.first = pinsIn;
    s_d.second = s_q.first;
  end

  // Chip select idles high so the reset value is all ones
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign pinsOut = s_q.second;

endmodule

/* File: sfrep_buf.sv */
// Two-entry buffer for received page bytes
`timescale 1ns/1ps
module sfrep_buf
  import sfrep_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [BUF_W-1:0] inData,
  // Draining side
  output logic outValid,
  input wire logic outReady,
  output logic [BUF_W-1:0] outData
);

  typedef struct packed {
    logic [BUF_DEPTH-1:0][BUF_W-1:0] data;
    logic [BUF_DEPTH-1:0] vld;
  } sfrep_buf_type;

  sfrep_buf_type s_q, s_d;

  // Head always sits in entry zero so both outputs come from flops
  always_comb begin
    s_d = s_q;
    if (s_q.vld[0] && outReady) begin
      for (int i = 0; i < BUF_DEPTH - 1; i++) begin
        s_d.data[i] = s_q.data[i + 1];
        s_d.vld[i] = s_q.vld[i + 1];
      end
      s_d.vld[BUF_DEPTH-1] = 1'b0;
    end
    if (inValid && !s_q.vld[BUF_DEPTH-1]) begin
      if (!s_d.vld[0]) begin
        s_d.data[0] = inData;
        s_d.vld[0] = 1'b1;
      end else begin
        s_d.data[1] = inData;
        s_d.vld[1] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign inReady = !s_q.vld[BUF_DEPTH-1];
  assign outValid = s_q.vld[0];
  assign outData = s_q.data[0];

endmodule

/* File: sfrep_core.sv */
// Serial flash command sequencer: reads, erases, page writes, pause
// Summary of operation
// - 03h plus address reads bytes out
// - Sample inputs on rise, drive on fall
// - Address increments per byte, wraps to zero
// - Chip select high ends read, lines released
// - 03h data begins falling edge clock 31
// - 0Bh adds dummy byte, data at 39
// - 3Bh outputs dual data, byte per four
// - Dual: odd bits line one, even zero
// - BBh address over both lines, 12 clocks
// - Four dummy clocks, data at clock 23
// - 20h/D7h erase 4K region, bits 19-12
// - D8h erase 64K region, bits 19-16
// - 60h/C7h erase whole array
// - Erase/write timed internally, busy shows completion
// - 02h and 0Ah same, 0Ah slower
// - Page write within page, starts at deselect
// - Over 256 bytes: last 256 kept
// - B0h pauses erase or write quickly
// - Commands refused during pause recovery
// - Paused: reads, status, continue accepted
// - New erase/write cancels pause
// - Pause flag set; cleared by 30h or write
// - Write-enable latch gates, cleared on completion
// - Status bit 0 busy during operation
`timescale 1ns/1ps
module sfrep_core
  import sfrep_pkg::*;
#(
  parameter int SMALL_ERASE_CYCLES = SMALL_ERASE_CYC,
  parameter int BLOCK_ERASE_CYCLES = BLOCK_ERASE_CYC,
  parameter int FULL_ERASE_CYCLES = FULL_ERASE_CYC,
  parameter int PAGE_WRITE_CYCLES = PAGE_WRITE_CYC,
  parameter int PAGE_WRITE_LC_CYCLES = PAGE_WRITE_LC_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Serial pins
  input wire logic chipSelect_n,
  input wire logic serialClock,
  input wire logic ioLineZeroIn,
  output logic ioLineZeroOut,
  output logic ioLineZeroOe,
  input wire logic ioLineOneIn,
  output logic ioLineOneOut,
  output logic ioLineOneOe,
  // Array read port
  output logic [ADDR_W-1:0] memAddr,
  input wire logic [7:0] memData,
  // Array operation start
  output logic opStart,
  output logic [1:0] opKind,
  output logic opLowCurrent,
  output logic [ADDR_W-1:0] opAddr,
  // Page bytes toward the array
  output logic pgmValid,
  input wire logic pgmReady,
  output logic [7:0] pgmData,
  output logic [ADDR_W-1:0] pgmAddr,
  // Status
  output logic busy,
  output logic writeUnlocked,
  output logic pausedFlag
);

  typedef struct packed {
    sfrep_phase_type phase;
    logic [7:0] cmd;
    logic [7:0] inSh;
    logic [4:0] cnt;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] memAddr;
    logic [7:0] col;
    logic dual;
    logic stat;
    logic loaded;
    logic [7:0] outSh;
    logic [2:0] outCnt;
    logic io0Out;
    logic io1Out;
    logic oe0;
    logic oe1;
    logic pushPend;
    logic [7:0] pushData;
    logic [ADDR_W-1:0] pushAddr;
    logic wel;
    logic busy;
    logic paused;
    logic [8:0] recover;
    logic [TIMER_W-1:0] timer;
    logic opStart;
    sfrep_op_type opKind;
    logic opLowCurrent;
    logic [ADDR_W-1:0] opAddr;
    logic csPrev;
    logic sckPrev;
  } sfrep_state_type;

  sfrep_state_type s_q, s_d;
  logic [3:0] pinsSync;
  logic csS, sckS, io0S, io1S;
  logic rise, fall, addrLast, startOp, lowCur, bufInReady;
  logic [7:0] shiftByte, outByte, statusByte;
  sfrep_op_type kind;
  logic [ADDR_W-1:0] base;
  logic [TIMER_W-1:0] load;

  // ==========================================================================
  // Pin synchronisation and page byte buffer
  sfrep_sync u_sfrep_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pinsIn({ioLineOneIn, ioLineZeroIn, serialClock, chipSelect_n}),
    .pinsOut(pinsSync)
  );
  assign {io1S, io0S, sckS, csS} = pinsSync;

  sfrep_buf u_sfrep_buf (
    .clock(clock),
    .rst_n(rst_n),
    .inValid(s_q.pushPend),
    .inReady(bufInReady),
    .inData({s_q.pushAddr, s_q.pushData}),
    .outValid(pgmValid),
    .outReady(pgmReady),
    .outData({pgmAddr, pgmData})
  );

  // ==========================================================================
  // Command acceptance
  function automatic logic isRead(input logic [7:0] c);
    return c inside {CMD_LOW_POWER_READ, CMD_FAST_READ, CMD_DUAL_OUTPUT_READ,
      CMD_DUAL_IO_READ};
  endfunction

  function automatic logic isWrite(input logic [7:0] c);
    return c inside {CMD_SMALL_BLOCK_ERASE_A, CMD_SMALL_BLOCK_ERASE_B,
      CMD_BLOCK_ERASE, CMD_FULL_ARRAY_ERASE_A, CMD_FULL_ARRAY_ERASE_B,
      CMD_PAGE_WRITE, CMD_PAGE_WRITE_LOW_CURRENT};
  endfunction

  function automatic logic cmdAllowed(input logic [7:0] c, input logic bsy,
      input logic pau, input logic rec);
    logic ok;
    ok = 1'b1;
    if (rec) begin
      ok = 1'b0;
    end else if (pau) begin
      ok = isRead(c) || isWrite(c) || c == CMD_STATUS_READ
        || c == CMD_WRITE_CONTINUE || c == CMD_WRITE_UNLOCK;
    end else if (bsy) begin
      ok = c == CMD_STATUS_READ || c == CMD_WRITE_PAUSE;
    end
    return ok;
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.opStart = 1'b0;
    s_d.csPrev = csS;
    s_d.sckPrev = sckS;
    rise = !csS && sckS && !s_q.sckPrev;
    fall = !csS && !sckS && s_q.sckPrev;
    shiftByte = {s_q.inSh[6:0], io0S};
    outByte = s_q.outSh;
    addrLast = 1'b0;
    startOp = 1'b0;
    lowCur = 1'b0;
    kind = OP_SMALL;
    statusByte = 8'h00;
    statusByte[ST_BUSY] = s_q.busy;
    statusByte[ST_WEL] = s_q.wel;
    statusByte[ST_PAUSED] = s_q.paused;
    if (s_q.pushPend && bufInReady) begin
      s_d.pushPend = 1'b0;
    end
    // Busy stays up through pause recovery so software sees not-ready
    if (s_q.recover != 9'h000) begin
      s_d.recover = s_q.recover - 9'h001;
      if (s_q.recover == 9'h001) begin
        s_d.busy = 1'b0;
      end
    end else if (s_q.busy && !s_q.paused) begin
      if (s_q.timer <= TIMER_W'(1)) begin
        s_d.busy = 1'b0;
        s_d.wel = 1'b0;
      end else begin
        s_d.timer = s_q.timer - TIMER_W'(1);
      end
    end
    if (csS) begin
      s_d.phase = PH_CMD;
      s_d.cnt = 5'h00;
      s_d.outCnt = 3'h0;
      s_d.oe0 = 1'b0;
      s_d.oe1 = 1'b0;
      s_d.stat = 1'b0;
      s_d.loaded = 1'b0;
      if (!s_q.csPrev && s_q.phase == PH_HOLD) begin
        case (s_q.cmd)
          CMD_WRITE_UNLOCK: begin
            s_d.wel = 1'b1;
          end
          CMD_WRITE_LOCK: begin
            if (!s_q.busy) s_d.wel = 1'b0;
          end
          CMD_WRITE_PAUSE: begin
            if (s_q.busy && !s_q.paused) begin
              s_d.paused = 1'b1;
              s_d.recover = PAUSE_RECOVERY_CYC;
            end
          end
          CMD_WRITE_CONTINUE: begin
            if (s_q.paused) begin
              s_d.paused = 1'b0;
              s_d.busy = 1'b1;
            end
          end
          CMD_SMALL_BLOCK_ERASE_A, CMD_SMALL_BLOCK_ERASE_B: begin
            startOp = s_q.wel;
            kind = OP_SMALL;
          end
          CMD_BLOCK_ERASE: begin
            startOp = s_q.wel;
            kind = OP_BLOCK;
          end
          CMD_FULL_ARRAY_ERASE_A, CMD_FULL_ARRAY_ERASE_B: begin
            startOp = s_q.wel;
            kind = OP_FULL;
          end
          default: ;
        endcase
      end
      // Only whole bytes, at least one, make a valid page write
      if (!s_q.csPrev && s_q.phase == PH_DIN && s_q.cnt == 5'h00 && s_q.loaded) begin
        startOp = s_q.wel;
        kind = OP_PAGE;
        lowCur = s_q.cmd == CMD_PAGE_WRITE_LOW_CURRENT;
      end
    end else if (rise) begin
      case (s_q.phase)
        PH_CMD: begin
          s_d.inSh = shiftByte;
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == CMD_LAST) begin
            s_d.cmd = shiftByte;
            s_d.cnt = 5'h00;
            s_d.dual = shiftByte inside {CMD_DUAL_OUTPUT_READ, CMD_DUAL_IO_READ};
            if (!cmdAllowed(shiftByte, s_q.busy, s_q.paused, s_q.recover != 9'h000)) begin
              s_d.phase = PH_SKIP;
            end else if (isRead(shiftByte) || (isWrite(shiftByte)
                && !(shiftByte inside {CMD_FULL_ARRAY_ERASE_A, CMD_FULL_ARRAY_ERASE_B}))) begin
              s_d.phase = PH_ADDR;
            end else if (shiftByte == CMD_STATUS_READ) begin
              s_d.phase = PH_DOUT;
              s_d.stat = 1'b1;
            end else begin
              s_d.phase = PH_HOLD;
            end
          end
        end
        PH_ADDR: begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cmd == CMD_DUAL_IO_READ) begin
            s_d.addr = {s_q.addr[ADDR_W-3:0], io1S, io0S};
            addrLast = s_q.cnt == ADDR_LAST_DUAL;
          end else begin
            s_d.addr = {s_q.addr[ADDR_W-2:0], io0S};
            addrLast = s_q.cnt == ADDR_LAST_SINGLE;
          end
          if (addrLast) begin
            s_d.cnt = 5'h00;
            s_d.memAddr = s_d.addr;
            s_d.col = s_d.addr[7:0];
            case (s_q.cmd)
              CMD_LOW_POWER_READ: s_d.phase = PH_DOUT;
              CMD_FAST_READ, CMD_DUAL_OUTPUT_READ, CMD_DUAL_IO_READ: s_d.phase = PH_DUMMY;
              CMD_PAGE_WRITE, CMD_PAGE_WRITE_LOW_CURRENT: s_d.phase = PH_DIN;
              default: s_d.phase = PH_HOLD;
            endcase
          end
        end
        PH_DUMMY: begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == (s_q.cmd == CMD_DUAL_IO_READ ? DUMMY_LAST_DUAL_IO : DUMMY_LAST)) begin
            s_d.phase = PH_DOUT;
            s_d.cnt = 5'h00;
          end
        end
        PH_DIN: begin
          s_d.inSh = shiftByte;
          s_d.cnt = (s_q.cnt == BYTE_LAST) ? 5'h00 : s_q.cnt + 5'h01;
          // The column wraps in the page, so later bytes overwrite older ones
          if (s_q.cnt == BYTE_LAST) begin
            s_d.pushPend = 1'b1;
            s_d.pushData = shiftByte;
            s_d.pushAddr = {s_q.addr[ADDR_W-1:8], s_q.col};
            s_d.col = s_q.col + 8'h01;
            s_d.loaded = 1'b1;
          end
        end
        PH_HOLD: s_d.phase = PH_SKIP;
        default: ;
      endcase
    end else if (fall && s_q.phase == PH_DOUT) begin
      if (s_q.outCnt == 3'h0) begin
        outByte = s_q.stat ? statusByte : memData;
        if (!s_q.stat) begin
          s_d.memAddr = s_q.memAddr + 20'h00001;
        end
      end
      s_d.io1Out = outByte[7];
      s_d.oe1 = 1'b1;
      if (s_q.dual) begin
        s_d.io0Out = outByte[6];
        s_d.oe0 = 1'b1;
        s_d.outSh = {outByte[5:0], 2'b00};
        s_d.outCnt = (s_q.outCnt == 3'h0) ? OUT_STEPS_DUAL : s_q.outCnt - 3'h1;
      end else begin
        s_d.outSh = {outByte[6:0], 1'b0};
        s_d.outCnt = (s_q.outCnt == 3'h0) ? OUT_STEPS_SINGLE : s_q.outCnt - 3'h1;
      end
    end
    case (kind)
      OP_SMALL: base = s_q.addr & SMALL_ERASE_MASK;
      OP_BLOCK: base = s_q.addr & BLOCK_ERASE_MASK;
      OP_PAGE: base = s_q.addr & PAGE_MASK;
      default: base = 20'h00000;
    endcase
    case (kind)
      OP_SMALL: load = TIMER_W'(SMALL_ERASE_CYCLES);
      OP_BLOCK: load = TIMER_W'(BLOCK_ERASE_CYCLES);
      OP_FULL: load = TIMER_W'(FULL_ERASE_CYCLES);
      default: load = lowCur ? TIMER_W'(PAGE_WRITE_LC_CYCLES) : TIMER_W'(PAGE_WRITE_CYCLES);
    endcase
    if (startOp) begin
      s_d.opStart = 1'b1;
      s_d.opKind = kind;
      s_d.opLowCurrent = lowCur;
      s_d.opAddr = base;
      s_d.busy = 1'b1;
      s_d.paused = 1'b0;
      s_d.recover = 9'h000;
      s_d.timer = load;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ioLineZeroOut = s_q.io0Out;
  assign ioLineZeroOe = s_q.oe0;
  assign ioLineOneOut = s_q.io1Out;
  assign ioLineOneOe = s_q.oe1;
  assign memAddr = s_q.memAddr;
  assign opStart = s_q.opStart;
  assign opKind = s_q.opKind;
  assign opLowCurrent = s_q.opLowCurrent;
  assign opAddr = s_q.opAddr;
  assign busy = s_q.busy;
  assign writeUnlocked = s_q.wel;
  assign pausedFlag = s_q.paused;

  // ==========================================================================
  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_release;
    csS |=> !ioLineOneOe && !ioLineZeroOe;
  endproperty
  a_release: assert property (p_release) else $error("lines driven while deselected");

  property p_wrap;
    fall && s_q.phase == PH_DOUT && !s_q.stat && s_q.outCnt == 3'h0 && s_q.memAddr == ADDR_TOP
      |=> memAddr == 20'h00000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("address did not wrap");

  property p_dual_split;
    fall && s_q.phase == PH_DOUT && s_q.dual && s_q.outCnt == 3'h0
      |=> ioLineOneOut == $past(memData[7]) && ioLineZeroOut == $past(memData[6]) && ioLineZeroOe;
  endproperty
  a_dual_split: assert property (p_dual_split) else $error("dual bit split wrong");

  property p_start_busy;
    opStart |-> busy && !pausedFlag;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start without busy");

  property p_done;
    busy && !pausedFlag && s_q.recover == 9'h000 && s_q.timer == TIMER_W'(1) && !s_d.opStart
      |=> !busy && !writeUnlocked;
  endproperty
  a_done: assert property (p_done) else $error("completion did not clear busy and latch");

  property p_pause;
    csS && !s_q.csPrev && s_q.phase == PH_HOLD && s_q.cmd == CMD_WRITE_PAUSE && busy && !pausedFlag
      |=> pausedFlag ##1 (busy && pausedFlag) [*8];
  endproperty
  a_pause: assert property (p_pause) else $error("pause not taken");

  property p_refuse;
    rise && s_q.phase == PH_CMD && s_q.cnt == CMD_LAST && s_q.recover != 9'h000
      |=> s_q.phase == PH_SKIP;
  endproperty
  a_refuse: assert property (p_refuse) else $error("command taken during recovery");

  property p_resume;
    csS && !s_q.csPrev && s_q.phase == PH_HOLD && s_q.cmd == CMD_WRITE_CONTINUE && pausedFlag
      |=> !pausedFlag && busy;
  endproperty
  a_resume: assert property (p_resume) else $error("continue did not clear pause");

  property p_col_wrap;
    rise && s_q.phase == PH_DIN && s_q.cnt == BYTE_LAST && s_q.col == 8'hff
      |=> s_q.col == 8'h00 && s_q.pushAddr[7:0] == 8'hff;
  endproperty
  a_col_wrap: assert property (p_col_wrap) else $error("page column did not wrap");

  property p_erase_base;
    opStart && opKind == OP_SMALL |-> opAddr[11:0] == 12'h000;
  endproperty
  a_erase_base: assert property (p_erase_base) else $error("small erase base unaligned");

endmodule

/* File: sfrep_host.sv */
// Host SPI controller model for the flash sequencer bench
`timescale 1ns/1ps
module sfrep_host (
  // Clock
  input wire logic clock,
  // Serial pins
  output logic chipSelect_n,
  output logic serialClock,
  output logic hostIo0,
  output logic hostIo1,
  input wire logic line0,
  input wire logic line1
);
  initial begin
    chipSelect_n = 1'b1;
    serialClock = 1'b0;
    hostIo0 = 1'b0;
    hostIo1 = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge clock);
  endtask
  // Mode 0, msb first, data moves while the clock is low
  task automatic put(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      hostIo0 = b[i];
      half();
      serialClock = 1'b1;
      half();
      serialClock = 1'b0;
    end
  endtask
  // Two bits a clock, the odd bit on line one
  task automatic putDual(input logic [7:0] b);
    for (int i = 7; i > 0; i -= 2) begin
      hostIo1 = b[i];
      hostIo0 = b[i - 1];
      half();
      serialClock = 1'b1;
      half();
      serialClock = 1'b0;
    end
  endtask
  // Sampled at the end of the high phase, before the fall that moves the data
  task automatic get(input bit dual, output logic [7:0] b);
    for (int i = 0; i < (dual ? 4 : 8); i++) begin
      half();
      serialClock = 1'b1;
      half();
      b = dual ? {b[5:0], line1, line0} : {b[6:0], line1};
      serialClock = 1'b0;
    end
  endtask
  task automatic sel(input logic [7:0] cmd);
    chipSelect_n = 1'b0;
    half();
    put(cmd);
  endtask
  // Released data line toggles so a stale level is never mistaken for a bit
  task automatic desel();
    half();
    chipSelect_n = 1'b1;
    hostIo0 = ~hostIo0;
    hostIo1 = ~hostIo1;
    half();
    half();
  endtask
endmodule

/* File: sfrep_core_tb_top.sv */
// Self-checking testbench for the flash command sequencer
`timescale 1ns/1ps
module sfrep_core_tb_top
  import sfrep_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic pgmReady = 1'b0;
  logic chipSelect_n, serialClock, hostIo0, hostIo1, line0, line1;
  logic ioLineZeroOut, ioLineZeroOe, ioLineOneOut, ioLineOneOe;
  logic [ADDR_W-1:0] memAddr, opAddr, pgmAddr, lastAddr;
  logic [7:0] memData, pgmData, sb;
  logic opStart, opLowCurrent, pgmValid, busy, writeUnlocked, pausedFlag, lastLc;
  logic [1:0] opKind, lastKind;
  logic [7:0] pgmQ[$];
  logic [ADDR_W-1:0] pgmAQ[$];
  logic [7:0] codes[5] = '{8'h20, 8'hd7, 8'hd8, 8'h60, 8'hc7};
  logic [1:0] kinds[5] = '{OP_SMALL, OP_SMALL, OP_BLOCK, OP_FULL, OP_FULL};
  logic [19:0] masks[5] = '{20'hff000, 20'hff000, 20'hf0000, 20'h00000, 20'h00000};
  int n_fail = 0;
  int checks = 0;
  int nStart = 0;
  int cyc = 0;
  // ==========================================================================
  // Pins, array and clock
  assign line0 = ioLineZeroOe ? ioLineZeroOut : hostIo0;
  assign line1 = ioLineOneOe ? ioLineOneOut : hostIo1;
  assign memData = memAddr[7:0] + memAddr[19:12] + 8'h5a;
  always #25 clock = ~clock;
  // Array side stalls every other cycle
  always @(negedge clock) pgmReady <= ~pgmReady;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (opStart === 1'b1) begin
      nStart <= nStart + 1;
      lastKind <= opKind;
      lastAddr <= opAddr;
      lastLc <= opLowCurrent;
    end
    if (pgmValid === 1'b1 && pgmReady === 1'b1) begin
      pgmQ.push_back(pgmData);
      pgmAQ.push_back(pgmAddr);
    end
    if (cyc == 30000) begin
      n_fail++;
      stop_test();
    end
  end
  sfrep_host u_sfrep_host (.clock(clock), .chipSelect_n(chipSelect_n),
    .serialClock(serialClock), .hostIo0(hostIo0), .hostIo1(hostIo1), .line0(line0),
    .line1(line1));
  sfrep_core #(.SMALL_ERASE_CYCLES(40), .BLOCK_ERASE_CYCLES(60), .FULL_ERASE_CYCLES(3000),
    .PAGE_WRITE_CYCLES(50), .PAGE_WRITE_LC_CYCLES(90)) u_sfrep_core (
    .clock(clock), .rst_n(rst_n), .chipSelect_n(chipSelect_n), .serialClock(serialClock),
    .ioLineZeroIn(line0), .ioLineZeroOut(ioLineZeroOut), .ioLineZeroOe(ioLineZeroOe),
    .ioLineOneIn(line1), .ioLineOneOut(ioLineOneOut), .ioLineOneOe(ioLineOneOe),
    .memAddr(memAddr), .memData(memData), .opStart(opStart), .opKind(opKind),
    .opLowCurrent(opLowCurrent), .opAddr(opAddr), .pgmValid(pgmValid),
    .pgmReady(pgmReady), .pgmData(pgmData), .pgmAddr(pgmAddr), .busy(busy),
    .writeUnlocked(writeUnlocked), .pausedFlag(pausedFlag));
  // ==========================================================================
  // Tasks
  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic sendAddr(input logic [19:0] a);
    u_sfrep_host.put({4'h0, a[19:16]});
    u_sfrep_host.put(a[15:8]);
    u_sfrep_host.put(a[7:0]);
  endtask
  task automatic cmdFrame(input logic [7:0] cmd, input bit withAddr, input logic [19:0] a);
    u_sfrep_host.sel(cmd);
    if (withAddr) sendAddr(a);
    u_sfrep_host.desel();
  endtask
  task automatic waitIdle();
    for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(negedge clock);
    chk(busy, 20'h0);
    chk(writeUnlocked, 20'h0);
  endtask
  task automatic rdChk(input logic [7:0] cmd, input logic [19:0] a, input bit dummy, input bit dual);
    logic [7:0] b;
    logic [19:0] x;
    u_sfrep_host.sel(cmd);
    if (cmd == 8'hbb) begin
      for (int k = 0; k < 4; k++) begin
        u_sfrep_host.putDual(k == 3 ? 8'hc3 : 8'(a >> 16 - 8 * k));
      end
    end else begin
      sendAddr(a);
      if (dummy) u_sfrep_host.put(8'hc3);
    end
    for (int k = 0; k < 2; k++) begin
      x = a + 20'(k);
      u_sfrep_host.get(dual, b);
      chk(b, 8'(x[7:0] + x[19:12] + 8'h5a));
    end
    u_sfrep_host.desel();
    chk({ioLineOneOe, ioLineZeroOe}, 20'h0);
  endtask
  // ==========================================================================
  // Sequence
  initial begin
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    repeat (5) @(negedge clock);
    rdChk(8'h03, 20'hfffff, 1'b0, 1'b0);
    rdChk(8'h0b, 20'h12345, 1'b1, 1'b0);
    rdChk(8'h3b, 20'hffffe, 1'b1, 1'b1);
    rdChk(8'hbb, 20'h6a5c3, 1'b1, 1'b1);
    cmdFrame(8'h06, 1'b0, 20'h0);
    cmdFrame(8'h04, 1'b0, 20'h0);
    chk(writeUnlocked, 20'h0);
    cmdFrame(8'h20, 1'b1, 20'h5a6b7);
    chk(nStart, 20'h0);
    for (int i = 0; i < 5; i++) begin
      cmdFrame(8'h06, 1'b0, 20'h0);
      chk(writeUnlocked, 20'h1);
      cmdFrame(codes[i], i < 3, 20'h5a6b7);
      chk(nStart, 20'(i + 1));
      chk({lastKind, lastAddr}, {kinds[i], 20'h5a6b7 & masks[i]});
      chk(busy, 20'h1);
      waitIdle();
    end
    for (int j = 0; j < 2; j++) begin
      pgmQ.delete();
      pgmAQ.delete();
      cmdFrame(8'h06, 1'b0, 20'h0);
      u_sfrep_host.sel(j ? 8'h02 : 8'h0a);
      sendAddr(20'h234fe);
      for (int k = 0; k < 3; k++) u_sfrep_host.put(8'ha1 + 8'(k));
      u_sfrep_host.desel();
      chk({lastKind, lastLc, lastAddr}, {OP_PAGE, ~j[0], 20'h23400});
      chk(pgmQ.size(), 20'h3);
      for (int k = 0; k < pgmQ.size(); k++) begin
        chk({pgmQ[k], pgmAQ[k]}, {8'ha1 + 8'(k), 12'h234, 8'hfe + 8'(k)});
      end
      waitIdle();
    end
    cmdFrame(8'h06, 1'b0, 20'h0);
    cmdFrame(8'h60, 1'b0, 20'h0);
    for (int p = 0; p < 2; p++) begin
      cmdFrame(8'hb0, 1'b0, 20'h0);
      chk({pausedFlag, busy}, 20'h3);
      cmdFrame(8'h30, 1'b0, 20'h0);
      chk({pausedFlag, busy}, 20'h3);
      repeat (340) @(negedge clock);
      chk({pausedFlag, busy}, 20'h2);
      u_sfrep_host.sel(8'h05);
      u_sfrep_host.get(1'b0, sb);
      u_sfrep_host.desel();
      chk(sb, 20'h42);
      if (p == 0) begin
        rdChk(8'h03, 20'h00100, 1'b0, 1'b0);
        cmdFrame(8'h30, 1'b0, 20'h0);
      end else begin
        cmdFrame(8'h06, 1'b0, 20'h0);
        cmdFrame(8'h20, 1'b1, 20'h5a6b7);
        chk({lastKind, lastAddr}, {OP_SMALL, 20'h5a000});
      end
      chk({pausedFlag, busy}, 20'h1);
    end
    waitIdle();
    stop_test();
  end
endmodule
